//--- core/fcd_pkg.sv
// package of constants and types for the four-channel transfer controller
package fcd_pkg;
   // channel count and register widths
   localparam int FCD_CH_N = 4;
   localparam int FCD_MODE_W = 6;
   localparam int FCD_FIFO_DEPTH = 16;
   // host port register and command codes on the four address lines
   localparam logic [3:0] FCD_A_STATUS_CMD = 4'h8;
   localparam logic [3:0] FCD_A_REQUEST = 4'h9;
   localparam logic [3:0] FCD_A_MASK_ONE = 4'hA;
   localparam logic [3:0] FCD_A_MODE = 4'hB;
   localparam logic [3:0] FCD_A_CLR_PTR = 4'hC;
   localparam logic [3:0] FCD_A_TEMP_MCLR = 4'hD;
   localparam logic [3:0] FCD_A_CLR_MASK = 4'hE;
   localparam logic [3:0] FCD_A_MASK_ALL = 4'hF;
   // global_control bit positions
   localparam int FCD_CMD_M2M = 0;
   localparam int FCD_CMD_HOLD0 = 1;
   localparam int FCD_CMD_DISABLE = 2;
   localparam int FCD_CMD_COMPRESS = 3;
   // channel_transfer_setup field positions (stored bits, data bits 7:2)
   localparam int FCD_MODE_TYPE_LSB = 0;
   localparam int FCD_MODE_AUTO = 2;
   localparam int FCD_MODE_DEC = 3;
   localparam int FCD_MODE_KIND_LSB = 4;
   // transfer kinds and transfer types
   localparam logic [1:0] FCD_KIND_DEMAND = 2'h0;
   localparam logic [1:0] FCD_KIND_SINGLE = 2'h1;
   localparam logic [1:0] FCD_KIND_BLOCK = 2'h2;
   localparam logic [1:0] FCD_TYPE_WRITE = 2'h1;
   localparam logic [1:0] FCD_TYPE_READ = 2'h2;
   // set/clear bit in request and single-mask data words
   localparam int FCD_SETBIT = 2;
   // values after reset or master clear
   localparam logic [7:0] FCD_CMD_RST = 8'h00;
   localparam logic [3:0] FCD_MASK_RST = 4'hF;
   localparam logic [15:0] FCD_CNT_ZERO = 16'h0000;
   // transfer sequencer states
   typedef enum logic [2:0] {
      dma_idle,
      dma_wait_grant,
      high_address_update_state,
      address_change_state,
      read_extension_state,
      read_write_execute_state
   } fcd_state_e;
endpackage

//--- core/fcd_dma_core.sv
// four-channel transfer controller core with its copy-data fifo
`timescale 1ns/1ps
`default_nettype none

// first-in first-out buffer for memory-to-memory copy bytes
module fcd_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_reg;
   logic [AW-1:0] rd_ptr_reg;
   logic [AW:0] count_reg;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   // honest full and empty from the occupancy count
   assign in_ready = (count_reg != AW'(0) + (AW+1)'(DEPTH));
   assign out_valid = (count_reg != '0);
   assign out_data = mem[rd_ptr_reg];

   // storage array, no reset needed
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_reg] <= in_data;
      end
   end

   // pointers wrap naturally, depth is a power of two
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
         count_reg <= '0;
      end else begin
         if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
         if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
         count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

// Behaviour
// - compressed timing shortens a transfer to two clocks, no read extension
// - compressed transfer is address change then execute, high update only on change
// - memory-to-memory transfers never use compressed timing
// - high update state drives high address byte on data lines, pulses latch strobe
// - latch output gate frees the latch; low address byte on own pins
// - block and demand runs repeat high update only on carry or borrow past bit 7, memory copy on every transfer
// - 16-bit running address, host read/write, steps after each transfer unless held for copy reads
// - count holds transfers minus one, wrap from zero to all ones flags end
// - auto-init reloads running address and count from start copies on end only
// - internal end without auto-init leaves running count at all ones
// - host write of running value writes start copy too; copies not readable
// - 6-bit setup per channel, low two data bits pick the channel
// - soft request per channel, unmasked, cleared by wrap, external end or reset
// - soft request honoured only in block kind; memory copy only on channel 0
// - end without auto-init sets the channel's block bit
// - block bits set or cleared singly or all at once; reset sets all
// - state flags 0-3 set on count wrap, cleared by reset or status read
// - state flags 4-7 show pending requests per channel
// - copy bytes buffered in the fifo, last one written kept in 8-bit register, readable until reset or master clear
// - software commands act on address decode alone, data ignored
// - master clear acts like reset on control, flags, requests, buffer, pointer
// - commands decode on chip select with write strobe using address only
module fcd_dma_core
   import fcd_pkg::*;
#(
   parameter int FIFO_DEPTH = FCD_FIFO_DEPTH
) (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic chip_select_n,
   input wire logic io_read_strobe_n_in,
   input wire logic io_write_strobe_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] data_in,
   output logic [7:0] data_out,
   output logic data_oe,
   output logic [7:0] addr_out,
   output logic addr_oe,
   output logic io_read_strobe_n_out,
   output logic io_write_strobe_n_out,
   output logic mem_read_strobe_n,
   output logic mem_write_strobe_n,
   output logic strobe_oe,
   output logic high_byte_latch_strobe,
   output logic latch_output_gate,
   input wire logic [3:0] channel_request_in,
   output logic [3:0] channel_grant_out,
   output logic bus_hold_request,
   input wire logic bus_hold_grant,
   input wire logic end_of_process_n_in,
   output logic count_wrap_flag
);
   // two-stage synchronisers for every pin input
   localparam int SW = 23;
   logic [SW-1:0] sync1_reg;
   logic [SW-1:0] sync2_reg;
   wire [SW-1:0] pins = {chip_select_n, io_read_strobe_n_in,
      io_write_strobe_n_in, addr_in, data_in, channel_request_in,
      bus_hold_grant, end_of_process_n_in, 2'b00};
   wire cs_s = !sync2_reg[22];
   wire ior_s = !sync2_reg[21];
   wire iow_s = !sync2_reg[20];
   wire [3:0] a_s = sync2_reg[19:16];
   wire [7:0] d_s = sync2_reg[15:8];
   wire [3:0] channel_request_in_s = sync2_reg[7:4];
   wire grant_s = sync2_reg[3];
   wire ext_eop_s = !sync2_reg[2];

   // register file
   logic [15:0] run_addr_reg [FCD_CH_N];
   logic [15:0] run_cnt_reg [FCD_CH_N];
   logic [15:0] start_addr_reg [FCD_CH_N];
   logic [15:0] start_cnt_reg [FCD_CH_N];
   logic [FCD_MODE_W-1:0] setup_reg [FCD_CH_N];
   logic [7:0] control_reg;
   logic [3:0] block_reg;
   logic [3:0] soft_req_reg;
   logic [3:0] wrap_seen_reg;
   logic [7:0] copy_buf_reg;
   logic ptr_reg;
   logic wr_prev_reg;
   logic rd_prev_reg;
   logic [3:0] rd_addr_reg;
   fcd_state_e state_reg;
   fcd_state_e state_next;
   logic [1:0] ch_reg;
   logic m2m_reg;
   logic phase_reg;

   // host access decode, only while idle or waiting and the bus is not granted
   wire host_ok = (state_reg == dma_idle || state_reg == dma_wait_grant)
      && !grant_s;
   wire wr_sel = cs_s && iow_s;
   wire rd_sel = cs_s && ior_s;
   wire wr_go = wr_sel && !wr_prev_reg && host_ok;
   wire rd_end = !rd_sel && rd_prev_reg;
   wire wr_chan = wr_go && !a_s[3];
   wire [1:0] wr_ch = a_s[2:1];
   wire rd_chan = rd_end && !rd_addr_reg[3];
   wire wr_ctl = wr_go && (a_s == FCD_A_STATUS_CMD);
   wire wr_req = wr_go && (a_s == FCD_A_REQUEST);
   wire wr_mask1 = wr_go && (a_s == FCD_A_MASK_ONE);
   wire wr_mode = wr_go && (a_s == FCD_A_MODE);
   wire clr_ptr = wr_go && (a_s == FCD_A_CLR_PTR);
   wire mclr = wr_go && (a_s == FCD_A_TEMP_MCLR);
   wire clr_mask = wr_go && (a_s == FCD_A_CLR_MASK);
   wire wr_mask_all = wr_go && (a_s == FCD_A_MASK_ALL);
   wire rd_status = rd_end && (rd_addr_reg == FCD_A_STATUS_CMD);

   // host read data: running values by byte pointer, flags, copy buffer
   wire [1:0] rd_ch = a_s[2:1];
   wire [15:0] rd_word = a_s[0] ? run_cnt_reg[rd_ch] : run_addr_reg[rd_ch];
   wire [7:0] rd_byte = ptr_reg ? rd_word[15:8] : rd_word[7:0];
   wire [7:0] flags = {channel_request_in_s | soft_req_reg, wrap_seen_reg};
   wire [7:0] rd_data = !a_s[3] ? rd_byte :
      (a_s == FCD_A_STATUS_CMD) ? flags :
      (a_s == FCD_A_TEMP_MCLR) ? copy_buf_reg : 8'h00;

   // request resolution, fixed priority with channel 0 highest
   logic [3:0] soft_ok;
   always_comb begin
      for (int i = 0; i < FCD_CH_N; i++) begin
         soft_ok[i] = soft_req_reg[i] &&
            (setup_reg[i][FCD_MODE_KIND_LSB +: 2] == FCD_KIND_BLOCK) &&
            (!control_reg[FCD_CMD_M2M] || i == 0);
      end
   end
   wire [3:0] req_vec = (channel_request_in_s & ~block_reg) | soft_ok;
   wire any_req = (req_vec != 4'h0) && !control_reg[FCD_CMD_DISABLE];
   wire [1:0] win_ch = req_vec[0] ? 2'd0 : req_vec[1] ? 2'd1 :
      req_vec[2] ? 2'd2 : 2'd3;
   wire win_m2m = control_reg[FCD_CMD_M2M] && soft_ok[0] && win_ch == 2'd0;

   // per-transfer address and count stepping
   wire [1:0] x_ch = m2m_reg ? {1'b0, phase_reg} : ch_reg;
   wire [1:0] c_ch = m2m_reg ? 2'd1 : ch_reg;
   wire [15:0] x_addr = run_addr_reg[x_ch];
   wire [15:0] x_cnt = run_cnt_reg[c_ch];
   wire x_hold = m2m_reg && !phase_reg && control_reg[FCD_CMD_HOLD0];
   wire x_dec = setup_reg[x_ch][FCD_MODE_DEC];
   wire [15:0] a_step = x_hold ? x_addr :
      x_dec ? x_addr - 16'h0001 : x_addr + 16'h0001;
   wire hi_change = (a_step[15:8] != x_addr[15:8]);
   wire cnt_step = !m2m_reg || phase_reg;
   wire tc_now = cnt_step && (x_cnt == FCD_CNT_ZERO);
   wire end_now = cnt_step && (tc_now || ext_eop_s);
   wire [1:0] kind = setup_reg[ch_reg][FCD_MODE_KIND_LSB +: 2];
   wire x_done = (state_reg == read_write_execute_state);
   wire compress = control_reg[FCD_CMD_COMPRESS] && !m2m_reg;
   wire auto_on = setup_reg[c_ch][FCD_MODE_AUTO];

   // copy buffer between copy read and copy write
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   wire fifo_push = x_done && m2m_reg && !phase_reg;
   wire fifo_pop = x_done && m2m_reg && phase_reg && fifo_out_valid;
   fcd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_copy_fifo (
      .mclk(mclk),
      .rst_b(rst_b),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(d_s),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_pop),
      .out_data(fifo_out_data)
   );

   // continue decision after an execute state
   logic go_on;
   always_comb begin
      go_on = 1'b0;
      if (m2m_reg) begin
         go_on = phase_reg ? (!end_now && fifo_in_ready) : 1'b1;
      end else if (!end_now) begin
         go_on = (kind == FCD_KIND_BLOCK) ||
            (kind == FCD_KIND_DEMAND && channel_request_in_s[ch_reg]);
      end
   end

   // transfer sequencer next state
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         dma_idle: begin
            if (any_req) state_next = dma_wait_grant;
         end
         dma_wait_grant: begin
            if (!any_req) begin
               state_next = dma_idle;
            end else if (grant_s && fifo_in_ready) begin
               state_next = high_address_update_state;
            end
         end
         high_address_update_state: begin
            state_next = address_change_state;
         end
         address_change_state: begin
            state_next = compress ? read_write_execute_state
               : read_extension_state;
         end
         read_extension_state: begin
            state_next = read_write_execute_state;
         end
         read_write_execute_state: begin
            if (!go_on) begin
               state_next = dma_idle;
            end else if (hi_change || m2m_reg) begin
               state_next = high_address_update_state;
            end else begin
               state_next = address_change_state;
            end
         end
         default: state_next = dma_idle;
      endcase
   end

   // synchronisers and strobe history
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         sync1_reg <= '1;
         sync2_reg <= '1;
         wr_prev_reg <= 1'b0;
         rd_prev_reg <= 1'b0;
         rd_addr_reg <= 4'h0;
      end else begin
         sync1_reg <= pins;
         sync2_reg <= sync1_reg;
         wr_prev_reg <= wr_sel;
         rd_prev_reg <= rd_sel && host_ok;
         if (rd_sel) rd_addr_reg <= a_s;
      end
   end

   // sequencer state and channel selection
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         state_reg <= dma_idle;
         ch_reg <= 2'd0;
         m2m_reg <= 1'b0;
         phase_reg <= 1'b0;
      end else begin
         state_reg <= mclr ? dma_idle : state_next;
         if (state_reg == dma_wait_grant) begin
            ch_reg <= win_ch;
            m2m_reg <= win_m2m;
            phase_reg <= 1'b0;
         end else if (x_done && m2m_reg) begin
            phase_reg <= !phase_reg;
         end
      end
   end

   // running values, start copies and per-channel setup
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         for (int i = 0; i < FCD_CH_N; i++) begin
            run_addr_reg[i] <= 16'h0000;
            run_cnt_reg[i] <= 16'h0000;
            start_addr_reg[i] <= 16'h0000;
            start_cnt_reg[i] <= 16'h0000;
            setup_reg[i] <= '0;
         end
      end else begin
         if (wr_chan && !a_s[0]) begin
            if (ptr_reg) begin
               run_addr_reg[wr_ch][15:8] <= d_s;
               start_addr_reg[wr_ch][15:8] <= d_s;
            end else begin
               run_addr_reg[wr_ch][7:0] <= d_s;
               start_addr_reg[wr_ch][7:0] <= d_s;
            end
         end
         if (wr_chan && a_s[0]) begin
            if (ptr_reg) begin
               run_cnt_reg[wr_ch][15:8] <= d_s;
               start_cnt_reg[wr_ch][15:8] <= d_s;
            end else begin
               run_cnt_reg[wr_ch][7:0] <= d_s;
               start_cnt_reg[wr_ch][7:0] <= d_s;
            end
         end
         if (wr_mode) setup_reg[d_s[1:0]] <= d_s[7:2];
         if (x_done) begin
            run_addr_reg[x_ch] <= a_step;
            if (cnt_step) run_cnt_reg[c_ch] <= x_cnt - 16'h0001;
            if (end_now && auto_on) begin
               run_addr_reg[c_ch] <= start_addr_reg[c_ch];
               run_cnt_reg[c_ch] <= start_cnt_reg[c_ch];
            end
         end
      end
   end

   // control, block bits, soft requests, flags, pointer and copy buffer
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         control_reg <= FCD_CMD_RST;
         block_reg <= FCD_MASK_RST;
         soft_req_reg <= 4'h0;
         wrap_seen_reg <= 4'h0;
         copy_buf_reg <= 8'h00;
         ptr_reg <= 1'b0;
      end else if (mclr) begin
         control_reg <= FCD_CMD_RST;
         block_reg <= FCD_MASK_RST;
         soft_req_reg <= 4'h0;
         wrap_seen_reg <= 4'h0;
         copy_buf_reg <= 8'h00;
         ptr_reg <= 1'b0;
      end else begin
         if (wr_ctl) control_reg <= d_s;
         if (wr_req) soft_req_reg[d_s[1:0]] <= d_s[FCD_SETBIT];
         if (wr_mask1) block_reg[d_s[1:0]] <= d_s[FCD_SETBIT];
         if (wr_mask_all) block_reg <= d_s[3:0];
         if (clr_mask) block_reg <= 4'h0;
         if (clr_ptr) begin
            ptr_reg <= 1'b0;
         end else if (wr_chan || rd_chan) begin
            ptr_reg <= !ptr_reg;
         end
         if (rd_status) wrap_seen_reg <= 4'h0;
         if (x_done && end_now) begin
            if (tc_now) wrap_seen_reg[c_ch] <= 1'b1;
            soft_req_reg[c_ch] <= 1'b0;
            if (m2m_reg) soft_req_reg[0] <= 1'b0;
            if (!auto_on) block_reg[c_ch] <= 1'b1;
         end
         if (fifo_pop) copy_buf_reg <= fifo_out_data;
      end
   end

   // registered pin outputs, one clock behind the sequencer state
   wire in_s1 = (state_reg == high_address_update_state);
   wire active = (state_reg != dma_idle) && (state_reg != dma_wait_grant);
   wire rd_phase = (state_reg == read_extension_state) || x_done;
   wire [1:0] x_type = setup_reg[ch_reg][FCD_MODE_TYPE_LSB +: 2];
   wire do_mr = m2m_reg ? !phase_reg : (x_type == FCD_TYPE_READ);
   wire do_iow = !m2m_reg && (x_type == FCD_TYPE_READ);
   wire do_ior = !m2m_reg && (x_type == FCD_TYPE_WRITE);
   wire do_mw = m2m_reg ? phase_reg : (x_type == FCD_TYPE_WRITE);
   wire [7:0] dout_next = in_s1 ? x_addr[15:8] :
      (x_done && m2m_reg && phase_reg) ? fifo_out_data : rd_data;
   wire doe_next = in_s1 || (x_done && m2m_reg && phase_reg) ||
      (rd_sel && host_ok);
   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         data_out <= 8'h00;
         data_oe <= 1'b0;
         addr_out <= 8'h00;
         addr_oe <= 1'b0;
         strobe_oe <= 1'b0;
         io_read_strobe_n_out <= 1'b1;
         io_write_strobe_n_out <= 1'b1;
         mem_read_strobe_n <= 1'b1;
         mem_write_strobe_n <= 1'b1;
         high_byte_latch_strobe <= 1'b0;
         latch_output_gate <= 1'b0;
         channel_grant_out <= 4'h0;
         bus_hold_request <= 1'b0;
         count_wrap_flag <= 1'b0;
      end else begin
         data_out <= dout_next;
         data_oe <= doe_next;
         addr_out <= x_addr[7:0];
         addr_oe <= active;
         strobe_oe <= active;
         io_read_strobe_n_out <= !(rd_phase && do_ior);
         io_write_strobe_n_out <= !(x_done && do_iow);
         mem_read_strobe_n <= !(rd_phase && do_mr);
         mem_write_strobe_n <= !(x_done && do_mw);
         high_byte_latch_strobe <= in_s1;
         latch_output_gate <= active;
         channel_grant_out <= (active && !m2m_reg) ?
            4'(1 << ch_reg) : 4'h0;
         bus_hold_request <= (state_reg != dma_idle);
         count_wrap_flag <= x_done && tc_now;
      end
   end
endmodule

`default_nettype wire

//--- dv/fcd_dma_core_chk.sv
// port-level assertions for the four-channel transfer controller
`timescale 1ns/1ps
`default_nettype none
module fcd_dma_core_chk (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic data_oe,
   input wire logic addr_oe,
   input wire logic strobe_oe,
   input wire logic mem_read_strobe_n,
   input wire logic mem_write_strobe_n,
   input wire logic high_byte_latch_strobe,
   input wire logic latch_output_gate,
   input wire logic [3:0] channel_grant_out,
   input wire logic bus_hold_request,
   input wire logic count_wrap_flag
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   // latch strobe is a lone pulse carrying the high byte
   hb_pulse_a: assert property (high_byte_latch_strobe |=>
      !high_byte_latch_strobe) else $error("latch strobe too long");
   hb_drive_a: assert property (high_byte_latch_strobe |->
      data_oe && latch_output_gate && bus_hold_request)
      else $error("latch strobe without data or gate");
   addr_gate_a: assert property (latch_output_gate |-> addr_oe)
      else $error("gate without low address");
   // strobe widths: write one cycle, read at most two
   wr_width_a: assert property (!mem_write_strobe_n |=>
      mem_write_strobe_n) else $error("write strobe too wide");
   rd_width_a: assert property ($fell(mem_read_strobe_n) |->
      ##[1:2] mem_read_strobe_n) else $error("read strobe too wide");
   // end-of-count pulse lasts one clock and comes while the hold request is raised
   wrap_pulse_a: assert property (count_wrap_flag |=>
      !count_wrap_flag) else $error("wrap flag too long");
   wrap_busy_a: assert property (count_wrap_flag |->
      bus_hold_request) else $error("wrap outside service");
   // idle cycle leaves the bus undriven, also while in reset
   idle_quiet_a: assert property (!bus_hold_request &&
      !$past(bus_hold_request) |-> !strobe_oe && !addr_oe &&
      channel_grant_out == 4'h0) else $error("bus driven while idle");
   reset_quiet_a: assert property (disable iff (1'b0)
      !rst_b |-> !data_oe && !strobe_oe && !bus_hold_request)
      else $error("outputs active in reset");
endmodule
bind fcd_dma_core fcd_dma_core_chk u_chk (.mclk(mclk), .rst_b(rst_b),
   .data_oe(data_oe), .addr_oe(addr_oe), .strobe_oe(strobe_oe),
   .mem_read_strobe_n(mem_read_strobe_n),
   .mem_write_strobe_n(mem_write_strobe_n),
   .high_byte_latch_strobe(high_byte_latch_strobe),
   .latch_output_gate(latch_output_gate),
   .channel_grant_out(channel_grant_out),
   .bus_hold_request(bus_hold_request),
   .count_wrap_flag(count_wrap_flag));
`default_nettype wire

//--- dv/fcd_bus_model.sv
// bus-side partner: hold grant and external high address latch
`timescale 1ns/1ps
`default_nettype none
module fcd_bus_model (
   input wire logic mclk,
   input wire logic rst_b,
   input wire logic [3:0] grant_dly,
   input wire logic bus_hold_request,
   output logic bus_hold_grant,
   input wire logic high_byte_latch_strobe,
   input wire logic latch_output_gate,
   input wire logic [7:0] data_out,
   input wire logic [7:0] addr_out,
   output logic [15:0] bus_addr
);
   logic [3:0] cnt_reg;
   logic stb_reg;
   logic [7:0] byte_reg;
   logic [7:0] hi_reg;
   // grant follows the hold request after a chosen delay
   always_ff @(posedge mclk) begin
      if (!rst_b || !bus_hold_request) begin
         cnt_reg <= 4'h0;
         bus_hold_grant <= 1'b0;
      end else if (cnt_reg < grant_dly) begin
         cnt_reg <= cnt_reg + 4'h1;
      end else begin
         bus_hold_grant <= 1'b1;
      end
   end
   // latch takes the data lines on the strobe's trailing edge
   always_ff @(posedge mclk) begin
      stb_reg <= high_byte_latch_strobe;
      byte_reg <= data_out;
      if (stb_reg && !high_byte_latch_strobe) hi_reg <= byte_reg;
   end
   // released latch outputs float: show inverse
   assign bus_addr = latch_output_gate ? {hi_reg, addr_out}
      : ~{hi_reg, addr_out};
endmodule
`default_nettype wire

//--- dv/four_channel_dma_regs_timing_bench.sv
// self-checking bench for the four-channel transfer controller
`timescale 1ns/1ps
`default_nettype none
module four_channel_dma_regs_timing_bench;
   import fcd_pkg::*;
   logic mclk = 1'b0;
   logic rst_b = 1'b1;
   logic cs_n = 1'b1;
   logic ior_n = 1'b1;
   logic iow_n = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [7:0] hdata = 8'h00;
   logic [3:0] req = 4'h0;
   logic [3:0] gdly = 4'h5;
   wire logic [7:0] data_out, addr_out;
   wire logic hb_stb, gate, mwr_n, hold, grant, wrap;
   wire logic [3:0] grant_ch;
   wire logic [15:0] bus_addr;
   int n_fail = 0;
   int check_count = 0;
   always #4 mclk = ~mclk;
   fcd_dma_core u_dut (.mclk(mclk), .rst_b(rst_b), .chip_select_n(cs_n),
      .io_read_strobe_n_in(ior_n), .io_write_strobe_n_in(iow_n),
      .addr_in(addr), .data_in(hdata), .data_out(data_out), .data_oe(),
      .addr_out(addr_out), .addr_oe(), .io_read_strobe_n_out(),
      .io_write_strobe_n_out(), .mem_read_strobe_n(),
      .mem_write_strobe_n(mwr_n), .strobe_oe(),
      .high_byte_latch_strobe(hb_stb), .latch_output_gate(gate),
      .channel_request_in(req), .channel_grant_out(grant_ch),
      .bus_hold_request(hold), .bus_hold_grant(grant),
      .end_of_process_n_in(1'b1), .count_wrap_flag(wrap));
   fcd_bus_model u_bus (.mclk(mclk), .rst_b(rst_b), .grant_dly(gdly),
      .bus_hold_request(hold), .bus_hold_grant(grant),
      .high_byte_latch_strobe(hb_stb), .latch_output_gate(gate),
      .data_out(data_out), .addr_out(addr_out), .bus_addr(bus_addr));
   // verdict and end of run
   task automatic conclude();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic timeout();
      n_fail++;
      $display("unexpected at %0t: wait ran out", $time);
      conclude();
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // host cycles hold strobes five clocks low and five high
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      cs_n <= 1'b0;
      iow_n <= 1'b0;
      addr <= a;
      hdata <= d;
      cyc(5);
      cs_n <= 1'b1;
      iow_n <= 1'b1;
      cyc(5);
   endtask
   task automatic rd(input logic [3:0] a, output logic [7:0] d);
      cs_n <= 1'b0;
      ior_n <= 1'b0;
      addr <= a;
      cyc(4);
      @(negedge mclk);
      d = data_out;
      @(posedge mclk);
      cs_n <= 1'b1;
      ior_n <= 1'b1;
      cyc(5);
   endtask
   task automatic wr16(input logic [3:0] a, input logic [15:0] v);
      wr(FCD_A_CLR_PTR, 8'hFF);
      wr(a, v[7:0]);
      wr(a, v[15:8]);
   endtask
   task automatic rd16(input logic [3:0] a, output logic [15:0] v);
      wr(FCD_A_CLR_PTR, 8'hFF);
      rd(a, v[7:0]);
      rd(a, v[15:8]);
   endtask
   // program, serve and judge one channel
   task automatic run(input logic [1:0] ch, input logic [5:0] md,
         input logic [15:0] a0, input int n, input int hb, input int gap,
         input logic [15:0] a_end, input logic [15:0] c_end);
      int s = 0;
      int w = 0;
      int last = 0;
      int g = 0;
      int t;
      logic done = 1'b0;
      logic [15:0] la = 16'h0000;
      logic [15:0] v;
      wr16({1'b0, ch, 1'b0}, a0);
      wr16({1'b0, ch, 1'b1}, 16'(n - 1));
      wr(FCD_A_MODE, {md, ch});
      wr(FCD_A_MASK_ONE, {6'h00, ch});
      req[ch] <= 1'b1;
      for (t = 0; t < 400; t++) begin
         @(negedge mclk);
         if (hb_stb === 1'b1) s++;
         if (grant_ch[ch] === 1'b1) req[ch] <= 1'b0;
         if (mwr_n === 1'b0) begin
            g = t - last;
            last = t;
            w++;
            la = bus_addr;
         end
         if (wrap === 1'b1) done = 1'b1;
         if (done && hold === 1'b0) break;
      end
      if (t == 400) timeout();
      @(posedge mclk);
      chk(16'(s), 16'(hb));
      chk(16'(w), 16'(n));
      chk(16'(g), 16'(gap));
      chk(la, md[3] ? a0 - 16'(n - 1) : a0 + 16'(n - 1));
      rd16({1'b0, ch, 1'b0}, v);
      chk(v, a_end);
      rd16({1'b0, ch, 1'b1}, v);
      chk(v, c_end);
      rd(FCD_A_STATUS_CMD, v[7:0]);
      chk(v[7:0], 8'h01 << ch);
      rd(FCD_A_STATUS_CMD, v[7:0]);
      chk(v[7:0], 8'h00);
   endtask
   task automatic reset_case();
      logic [7:0] d;
      rd(FCD_A_STATUS_CMD, d);
      chk(d, 8'h00);
      rd(FCD_A_TEMP_MCLR, d);
      chk(d, 8'h00);
      rd(FCD_A_REQUEST, d);
      chk(d, 8'h00);
      req[3] <= 1'b1;
      cyc(12);
      chk(hold, 1'b0);
      req[3] <= 1'b0;
   endtask
   // carry past bit 7, uncompressed, slow grant
   task automatic carry_case();
      run(2'd1, 6'h21, 16'h12FE, 4, 2, 3, 16'h1302, 16'hFFFF);
   endtask
   task automatic mask_case();
      logic [7:0] d;
      req[1] <= 1'b1;
      cyc(12);
      chk(hold, 1'b0);
      rd(FCD_A_STATUS_CMD, d);
      chk(d, 8'h20);
      req[1] <= 1'b0;
      cyc(4);
   endtask
   // compressed, decrementing, auto-init, prompt grant
   task automatic comp_case();
      gdly <= 4'h0;
      wr(FCD_A_STATUS_CMD, 8'h08);
      run(2'd2, 6'h2D, 16'h0200, 3, 2, 2, 16'h0200, 16'h0002);
   endtask
   task automatic soft_case();
      logic [7:0] d;
      wr16(4'h0, 16'h0000);
      wr16(4'h1, 16'h0000);
      wr(FCD_A_MODE, 8'h44);
      wr(FCD_A_MASK_ONE, 8'h00);
      wr(FCD_A_REQUEST, 8'h04);
      cyc(12);
      chk(hold, 1'b0);
      wr(FCD_A_REQUEST, 8'h00);
      wr16(4'h3, 16'h0000);
      wr(FCD_A_STATUS_CMD, 8'h09);
      wr(FCD_A_MODE, 8'h80);
      wr(FCD_A_REQUEST, 8'h04);
      cyc(12);
      rd(FCD_A_TEMP_MCLR, d);
      chk(d, 8'h04);
   endtask
   task automatic clear_case();
      int t;
      logic [7:0] d;
      gdly <= 4'hF;
      wr(FCD_A_TEMP_MCLR, 8'hFF);
      req[0] <= 1'b1;
      cyc(12);
      chk(hold, 1'b0);
      wr(FCD_A_CLR_MASK, 8'hFF);
      chk(hold, 1'b1);
      for (t = 0; t < 100 && grant_ch[0] !== 1'b1; t++) cyc(1);
      req[0] <= 1'b0;
      if (t == 100) timeout();
      cyc(30);
      rd(FCD_A_TEMP_MCLR, d);
      chk(d, 8'h00);
   endtask
   initial begin
      rst_b <= 1'b0;
      cyc(4);
      rst_b <= 1'b1;
      cyc(3);
      reset_case();
      carry_case();
      mask_case();
      comp_case();
      soft_case();
      clear_case();
      conclude();
   end
endmodule
`default_nettype wire
